// File: logic/itp_defines.vh
// constants for the interrupt test and promotion block
//
// Behaviour
// - test-enable writable: special mode, both masks set
// - test-enable clear: force writes ignored, reads live
// - test-enable set: decoder fed from force registers
// - pending requests captured when test-enable sets
// - 4-bit select field picks force register
// - force reads zero in normal modes
// - force write: special, test-enable, I mask set
// - force bit n requests vector low nibble 2n
// - one force register per eight interrupts, shared
// - select F: only bits 2:0 exist
// - unimplemented force register: no write, read zero
// - promotion register writable only with I mask set
// - promotion holds vector bits 7:1, top priority
// - bad promotion value selects vector F2
// - higher vector address ranks higher by default
`ifndef ITP_DEFINES_VH
`define ITP_DEFINES_VH

`define ITP_ADDR_TEST_CTRL   8'h15
`define ITP_ADDR_FORCE_WIN   8'h16
`define ITP_ADDR_TOP_PRIO    8'h1F
`define ITP_CTRL_FORCE_EN    4
`define ITP_CTRL_SEL_HI      3
`define ITP_CTRL_SEL_LO      0
`define ITP_SEL_TOP_GROUP    4'hF
`define ITP_TOP_GROUP_MASK   8'h07
`define ITP_PRIO_RESET       7'h79
`define ITP_PRIO_DEFAULT     7'h79
`define ITP_PRIO_MAX_VEC     8'hF2

`endif

// File: logic/itp_group_decode.v
// per-group request selection and ranking of the maskable requests
`timescale 1ns/1ps
`default_nettype none

module itp_group_decode #(
	parameter NGRP = 16
) (
	input  wire [NGRP*8-1:0] live_req,
	input  wire [NGRP*8-1:0] force_req,
	input  wire              force_en,
	input  wire [6:0]        prio_sel,
	output reg  [NGRP*8-1:0] dec_req,
	output reg               any_req,
	output reg  [7:0]        win_vec
);
	integer i;
	reg     promo_hit;

	always @* begin
		dec_req = force_en ? force_req : live_req;
		any_req = 1'b0;
		win_vec = 8'h00;
		// higher index scanned last wins, so higher vector ranks higher
		for (i = 0; i < NGRP*8; i = i + 1) begin
			if (dec_req[i] && (i < 8'h7A)) begin
				any_req = 1'b1;
				win_vec = {i[6:0], 1'b0};
			end
		end
		promo_hit = 1'b0;
		for (i = 0; i < NGRP*8; i = i + 1) begin
			if (dec_req[i] && (i[6:0] == prio_sel) && (i < 8'h7A))
				promo_hit = 1'b1;
		end
		if (promo_hit) begin
			win_vec = {prio_sel, 1'b0};
		end
	end
endmodule

`default_nettype wire

// File: logic/itp_sync2.v
// two-flop synchroniser for a bus of pin-level request inputs
`timescale 1ns/1ps
`default_nettype none

module itp_sync2 #(
	parameter W = 128
) (
	input  wire         ref_clk,
	input  wire         rst_n,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] meta_q;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_q   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

`default_nettype wire

// File: logic/itp_top.v
// interrupt test control, force registers and promotion register
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "itp_defines.vh"

module itp_top #(
	parameter NGRP = 16
) (
	input  wire              ref_clk,
	input  wire              rst_n,
	input  wire [7:0]        reg_addr,
	input  wire [7:0]        reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [7:0]        reg_rdata,
	input  wire              special_mode,
	input  wire              i_mask,
	input  wire              x_mask,
	input  wire [NGRP*8-1:0] irq_in,
	output reg  [NGRP*8-1:0] dec_req_q,
	output reg               any_req_q,
	output reg  [7:0]        win_vec_q
);
	localparam NREQ = NGRP*8;

	reg  [7:0]      ctrl_q;
	reg  [NREQ-1:0] force_q;
	reg  [6:0]      prio_q;
	wire [NREQ-1:0] live_req;
	wire [NREQ-1:0] dec_req;
	wire            any_req;
	wire [7:0]      win_vec;
	wire            force_en;
	wire [3:0]      sel;
	wire            sel_ok;
	wire [7:0]      sel_mask;
	reg  [7:0]      sel_live;
	reg  [7:0]      sel_force;
	reg  [7:0]      rdata_d;
	reg  [6:0]      prio_d;
	wire            wr_ctrl;
	wire            wr_force;
	wire            wr_prio;
	integer         k;
	integer         m;

	assign force_en = ctrl_q[`ITP_CTRL_FORCE_EN];
	assign sel      = ctrl_q[`ITP_CTRL_SEL_HI:`ITP_CTRL_SEL_LO];
	assign sel_ok   = ({28'h0000_000, sel} < NGRP);
	// top group holds only the F0..F4 vectors
	assign sel_mask = (sel == `ITP_SEL_TOP_GROUP) ? `ITP_TOP_GROUP_MASK : 8'hFF;

	assign wr_ctrl  = reg_wr && (reg_addr == `ITP_ADDR_TEST_CTRL);
	assign wr_force = reg_wr && (reg_addr == `ITP_ADDR_FORCE_WIN)
		&& special_mode && force_en && i_mask && sel_ok;
	assign wr_prio  = reg_wr && (reg_addr == `ITP_ADDR_TOP_PRIO) && i_mask;

	itp_sync2 #(
		.W(NREQ)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (irq_in),
		.sync_out (live_req)
	);

	itp_group_decode #(
		.NGRP(NGRP)
	) u_dec (
		.live_req  (live_req),
		.force_req (force_q),
		.force_en  (force_en),
		.prio_sel  (prio_q),
		.dec_req   (dec_req),
		.any_req   (any_req),
		.win_vec   (win_vec)
	);

	// window onto the selected group; one shared address for all groups
	always @* begin
		sel_live  = 8'h00;
		sel_force = 8'h00;
		for (k = 0; k < NREQ; k = k + 1) begin
			if ((k / 8) == sel) begin
				sel_live[k % 8]  = live_req[k];
				sel_force[k % 8] = force_q[k];
			end
		end
	end

	// out-of-range or above F2 falls back to the F2 source
	always @* begin
		if ((reg_wdata > `ITP_PRIO_MAX_VEC) || (reg_wdata[7:1] >= NREQ))
			prio_d = `ITP_PRIO_DEFAULT;
		else
			prio_d = reg_wdata[7:1];
	end

	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
		`ITP_ADDR_TEST_CTRL: begin
			rdata_d = {3'b000, ctrl_q[4:0]};
		end
		`ITP_ADDR_FORCE_WIN: begin
			if (special_mode && sel_ok) begin
				if (force_en)
					rdata_d = sel_force & sel_mask;
				else
					rdata_d = sel_live & sel_mask;
			end
		end
		`ITP_ADDR_TOP_PRIO: begin
			rdata_d = {prio_q, 1'b0};
		end
		default: begin
			rdata_d = 8'h00;
		end
		endcase
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_q    <= 8'h00;
			force_q   <= {NREQ{1'b0}};
			prio_q    <= `ITP_PRIO_RESET;
			reg_rdata <= 8'h00;
			dec_req_q <= {NREQ{1'b0}};
			any_req_q <= 1'b0;
			win_vec_q <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
			dec_req_q <= dec_req;
			any_req_q <= any_req;
			win_vec_q <= win_vec;
			if (wr_ctrl) begin
				ctrl_q[3:0] <= reg_wdata[3:0];
				if (special_mode && i_mask && x_mask)
					ctrl_q[`ITP_CTRL_FORCE_EN] <= reg_wdata[`ITP_CTRL_FORCE_EN];
			end
			// capture pending requests on the rising edge of force enable
			if (wr_ctrl && special_mode && i_mask && x_mask && !force_en
				&& reg_wdata[`ITP_CTRL_FORCE_EN]) begin
				force_q <= live_req;
			end else if (wr_force) begin
				// own loop index: the read window process already drives k
				for (m = 0; m < NREQ; m = m + 1) begin
					if (((m / 8) == sel) && sel_mask[m % 8])
						force_q[m] <= reg_wdata[m % 8];
				end
			end
			if (wr_prio)
				prio_q <= prio_d;
		end
	end
endmodule

`default_nettype wire

// File: tb/itp_properties.sv
// port checker for the interrupt test block
`timescale 1ns/1ps
`default_nettype none
module itp_properties #(
	parameter NGRP = 16
) (
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic [7:0]        reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	input wire logic              special_mode,
	input wire logic              i_mask,
	input wire logic              x_mask,
	input wire logic [NGRP*8-1:0] irq_in,
	input wire logic [NGRP*8-1:0] dec_req_q,
	input wire logic              any_req_q,
	input wire logic [7:0]        win_vec_q
);
	logic [3:0] sel_q;
	logic       en_q;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sel_q <= 4'h0;
			en_q <= 1'b0;
		end else if (reg_wr && reg_addr == 8'h15) begin
			sel_q <= reg_wdata[3:0];
			if (special_mode && i_mask && x_mask)
				en_q <= reg_wdata[4];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_ctrl_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h15
		|-> reg_rdata == {3'h0, en_q, sel_q}) else $error("control readback");
	a_force_top: assert property ($past(reg_rd) && $past(reg_addr) == 8'h16
		&& sel_q == 4'hF |-> reg_rdata[7:3] == 5'h00) else $error("top group bits");
	a_normal_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h16
		&& !$past(special_mode) |-> reg_rdata == 8'h00) else $error("normal read");
	a_prio_form: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1F
		|-> reg_rdata <= 8'hF2 && !reg_rdata[0]) else $error("promotion form");
	a_live_feed: assert property (!en_q && !$past(en_q)
		|-> dec_req_q == $past(irq_in, 3)) else $error("live path");
	a_force_hold: assert property (en_q && $past(en_q) && !$past(reg_wr)
		|=> $stable(dec_req_q)) else $error("forced path moved");
	a_win_form: assert property (win_vec_q <= 8'hF2 && !win_vec_q[0])
		else $error("winner out of range");
	a_any_match: assert property (any_req_q == |dec_req_q[NGRP*8-7:0])
		else $error("any request");
	cover property (en_q && reg_rd && reg_addr == 8'h16);
	cover property (reg_wr && reg_addr == 8'h1F && i_mask);
	cover property (any_req_q && win_vec_q == 8'hF2);
endmodule
`default_nettype wire

// File: tb/itp_peer.sv
// request sources: raise what the bench asks
`timescale 1ns/1ps
`default_nettype none
module itp_peer (
	input  wire logic         ref_clk,
	input  wire logic [127:0] want,
	output var  logic [127:0] irq_in
);
	always @(posedge ref_clk)
		irq_in <= want;
endmodule
`default_nettype wire

// File: tb/itp_top_tb.sv
// self-checking bench with register model
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("unexpected %0t %h %h", $time, a, e); end end
module itp_top_tb;
	logic         ref_clk, rst_n, reg_wr, reg_rd, special_mode, i_mask, x_mask, any_req_q;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, win_vec_q, ctl_m, prio_m;
	logic [7:0]   frc_m [16];
	logic [127:0] want, irq_in, dec_req_q;
	logic [31:0]  seed;
	int           miscompares, total_checks, cyc;
	itp_top #(.NGRP(16)) uut (.*);
	itp_peer peer (.*);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic finish_test();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		if (a == 8'h15 && special_mode && i_mask && x_mask) begin
			if (d[4] && !ctl_m[4])
				for (int g = 0; g < 16; g++)
					frc_m[g] = want[g*8 +: 8];
			ctl_m[4] = d[4];
		end
		if (a == 8'h15)
			ctl_m[3:0] = d[3:0];
		if (a == 8'h16 && special_mode && ctl_m[4] && i_mask)
			frc_m[ctl_m[3:0]] = d;
		if (a == 8'h1F && i_mask)
			prio_m = d > 8'hF2 ? 8'hF2 : d & 8'hFE;
	endtask
	task automatic rd(input logic [7:0] a);
		logic [7:0] e;
		e = a == 8'h15 ? ctl_m : a == 8'h1F ? prio_m : 8'h00;
		if (a == 8'h16 && special_mode)
			e = (ctl_m[4] ? frc_m[ctl_m[3:0]] : want[ctl_m[3:0]*8 +: 8])
				& (ctl_m[3:0] == 4'hF ? 8'h07 : 8'hFF);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CK(reg_rdata, e)
	endtask
	task automatic win();
		logic [7:0] e;
		logic       any;
		e = 8'h00;
		any = 1'b0;
		for (int v = 0; v <= 242; v += 2)
			if (frc_m[v/16][(v%16)/2]) begin
				e = v[7:0];
				any = 1'b1;
			end
		if (frc_m[prio_m[7:4]][prio_m[3:1]])
			e = prio_m;
		repeat (4) @(posedge ref_clk);
		#1;
		`CK(win_vec_q, e)
		`CK(any_req_q, any)
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, special_mode, i_mask, x_mask} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		want = '0;
		seed = 32'h0000_0039;
		ctl_m = 8'h00;
		prio_m = 8'hF2;
		frc_m = '{default: 8'h00};
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h15);
		rd(8'h1F);
		wr(8'h15, 8'h1F);
		rd(8'h15);
		rd(8'h16);
		@(posedge ref_clk);
		special_mode <= 1'b1;
		want <= {rnd(), rnd(), rnd(), rnd()};
		for (int s = 0; s < 16; s++) begin
			wr(8'h15, s[7:0]);
			rd(8'h16);
		end
		@(posedge ref_clk);
		i_mask <= 1'b1;
		wr(8'h16, 8'hFF);
		rd(8'h16);
		// x mask still clear: enable bit refused, select still taken
		wr(8'h15, 8'h10);
		rd(8'h15);
		@(posedge ref_clk);
		x_mask <= 1'b1;
		wr(8'h15, 8'h10);
		@(posedge ref_clk);
		want <= ~want;
		rd(8'h16);
		for (int s = 0; s < 16; s++) begin
			wr(8'h15, 8'h10 | s[7:0]);
			wr(8'h16, 8'(rnd()));
			rd(8'h16);
		end
		win();
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			i_mask <= k[0];
			wr(8'h1F, k < 4 ? 8'hF3 + 8'(k) : 8'(rnd()));
			wr(8'h16, 8'h00);
			rd(8'h1F);
			win();
		end
		finish_test();
	end
endmodule
bind itp_top itp_properties #(.NGRP(NGRP)) chk (.*);
`default_nettype wire
